// file: rtl/fork_pkg.sv
// Package: constants and types for the fork post and thread allocator
package fork_pkg;

  // ==================================================================
  // Sizes
  localparam int THREAD_COUNT_MAX = 32;
  localparam int MASK_WIDTH       = 32;
  localparam int TID_WIDTH        = 5;
  localparam int COUNT_WIDTH      = 6;
  localparam int WORD_WIDTH       = 32;
  localparam int PCX_WIDTH        = 3;
  localparam int PCX_COUNT        = 8;

  // ==================================================================
  // Reset values
  localparam logic [MASK_WIDTH-1:0]  MASK_RESET  = 32'hFFFF_FFFE;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 6'h01;
  localparam logic [TID_WIDTH-1:0]   TID_RESET   = 5'h00;

  // ==================================================================
  // Fork kind codes
  typedef enum logic [1:0] {
    KIND_NONE          = 2'h0,
    KIND_SINGLE_POST   = 2'h1,
    KIND_MULTI_POST    = 2'h2,
    KIND_HALTED        = 2'h3
  } fork_kind_t;

  // ==================================================================
  // Operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_POST_SINGLE,
    OP_POST_MULTI,
    OP_CLEAR,
    OP_TERMINATE,
    OP_JOIN,
    OP_IDLE,
    OP_FORBID
  } op_t;

  // ==================================================================
  // Outcome of an operation
  typedef enum logic [2:0] {
    RES_DONE,
    RES_RESTART,
    RES_IDLE,
    RES_CONTINUE,
    RES_ACCEPTED,
    RES_DEADLOCK_EXC,
    RES_DEADLOCK_TRAP
  } result_t;

  // ==================================================================
  // Fork event contents
  typedef struct packed {
    logic [WORD_WIDTH-1:0] frameArg;
    logic [WORD_WIDTH-1:0] targetPcStatus;
    logic [WORD_WIDTH-1:0] originPc;
    fork_kind_t            kind;
    logic [WORD_WIDTH-1:0] stack;
  } fork_event_t;

  // Request from a CPU
  typedef struct packed {
    op_t                   op;
    logic [PCX_WIDTH-1:0]  pcx;
    logic [TID_WIDTH-1:0]  thread_identifier_reg;
    logic [WORD_WIDTH-1:0] frameArg;
    logic [WORD_WIDTH-1:0] targetPcStatus;
    logic [WORD_WIDTH-1:0] originPc;
    logic [WORD_WIDTH-1:0] stack;
  } request_t;

  // Answer to a CPU
  typedef struct packed {
    result_t               result;
    logic                  carry;
    logic [TID_WIDTH-1:0]  thread_identifier_reg;
    fork_event_t           taken;
  } answer_t;

endpackage

// file: rtl/lsb_finder.sv
// Module: finds the least significant set bit of a mask
`timescale 1ns/1ps
module lsb_finder #(
  parameter int WIDTH = 32,
  parameter int IDX_W = 5
) (
  input  wire logic [WIDTH-1:0] mask,
  output logic                  found,
  output logic [IDX_W-1:0]      index
);
  if (WIDTH < 1 || WIDTH > (1 << IDX_W)) begin : g_bad_width
    $error("lsb_finder: index too narrow");
  end

  // Trailing-zero count, scanning from the top so the lowest wins
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end
endmodule

// file: rtl/fork_post_and_thread_allocator.sv
// Module: fork event registers and thread slot allocator for shared process contexts
`timescale 1ns/1ps
module fork_post_and_thread_allocator
  import fork_pkg::*;
#(
  parameter int CONTEXTS = PCX_COUNT
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                reqValid,
  input  wire fork_pkg::request_t  req,
  input  wire logic                storesDrained,
  output logic                     reqBusy,
  output logic                     ansValid,
  output fork_pkg::answer_t        ans,
  output logic [PCX_WIDTH-1:0]     monPcx,
  output logic                     monForkLock,
  output logic                     monPostedLock,
  output logic                     monAllocLock,
  output logic [MASK_WIDTH-1:0]    monMask,
  output logic [COUNT_WIDTH-1:0]   monCount
);
  import fork_pkg::*;

  // Elaboration-time checks of the configuration
  if (CONTEXTS < 1 || CONTEXTS > PCX_COUNT) begin : g_bad_contexts
    $error("CONTEXTS out of range");
  end
  if (MASK_WIDTH > (1 << TID_WIDTH) || THREAD_COUNT_MAX >= (1 << COUNT_WIDTH)) begin : g_bad_widths
    $error("thread index or count too narrow");
  end

  // ==================================================================
  // Per-context storage
  logic [PCX_COUNT-1:0]   forkLock;
  logic [PCX_COUNT-1:0]   postedLock;
  logic [PCX_COUNT-1:0]   allocLock;
  fork_event_t            forkEvt   [PCX_COUNT];
  logic [MASK_WIDTH-1:0]  threadMask[PCX_COUNT];
  logic [COUNT_WIDTH-1:0] threadCount[PCX_COUNT];

  // ==================================================================
  // Sequencer
  typedef enum {
    ST_IDLE,
    ST_POST_WRITE,
    ST_POST_LOCK,
    ST_JOIN_DRAIN,
    ST_JOIN_FINISH,
    ST_ACCEPT_READ,
    ST_ACCEPT_DONE
  } state_t;

  state_t                 state;
  request_t               cur;
  logic [COUNT_WIDTH-1:0] heldCount;
  logic [MASK_WIDTH-1:0]  heldMask;
  logic                   acceptSingle;
  fork_event_t            heldEvt;

  // Lowest free slot of the addressed context
  logic                   freeFound;
  logic [TID_WIDTH-1:0]   freeIndex;
  logic [PCX_WIDTH-1:0]   selPcx;

  assign selPcx = (state == ST_IDLE) ? req.pcx : cur.pcx;

  lsb_finder #(
    .WIDTH (MASK_WIDTH),
    .IDX_W (TID_WIDTH)
  ) u_lsb (
    .mask  (threadMask[selPcx]),
    .found (freeFound),
    .index (freeIndex)
  );

  // ==================================================================
  // Helper functions
  function automatic logic [MASK_WIDTH-1:0] bitOf(input logic [TID_WIDTH-1:0] idx);
    bitOf = MASK_WIDTH'(1) << idx;
  endfunction

  // Releasing a slot sets its mask bit again
  function automatic logic [MASK_WIDTH-1:0] releaseSlot(input logic [MASK_WIDTH-1:0] m,
                                                        input logic [TID_WIDTH-1:0]  t);
    releaseSlot = m | bitOf(t);
  endfunction

  // One thread fewer
  function automatic logic [COUNT_WIDTH-1:0] countDown(input logic [COUNT_WIDTH-1:0] c);
    countDown = c - COUNT_WIDTH'(1);
  endfunction

  // Kind code written by a post
  function automatic fork_kind_t postKind(input op_t o);
    postKind = (o == OP_POST_MULTI) ? KIND_MULTI_POST : KIND_SINGLE_POST;
  endfunction

  function automatic answer_t mkAns(input result_t r, input logic c,
                                    input logic [TID_WIDTH-1:0] t, input fork_event_t e);
    mkAns.result = r;
    mkAns.carry  = c;
    mkAns.thread_identifier_reg    = t;
    mkAns.taken  = e;
  endfunction

  // ==================================================================
  // Request decode
  logic take;
  assign take = reqValid && !reqBusy;

  // Fork is available to a receiver only when fully posted
  logic canReceive;
  assign canReceive = forkLock[selPcx] && postedLock[selPcx];

  // Idle takes a fork only from a receivable, non-full, posted, live context
  logic acceptOk;
  assign acceptOk = allocLock[selPcx] && freeFound && canReceive && forkEvt[selPcx].kind != KIND_HALTED;

  // ==================================================================
  // Main sequencer, lock bits and fork fields
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      cur          <= '0;
      heldCount    <= '0;
      heldMask     <= '0;
      acceptSingle <= 1'b0;
      heldEvt      <= '0;
      reqBusy      <= 1'b0;
      ansValid     <= 1'b0;
      ans          <= '0;
      forkLock     <= '0;
      postedLock   <= '0;
      allocLock    <= '1;
      for (int i = 0; i < PCX_COUNT; i++) begin
        forkEvt[i]     <= '0;
        threadMask[i]  <= MASK_RESET;
        threadCount[i] <= COUNT_RESET;
      end
    end else begin
      ansValid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            cur <= req;
            case (req.op)
              OP_POST_SINGLE, OP_POST_MULTI: begin
                if (forkLock[req.pcx]) begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_DONE, 1'b0, req.thread_identifier_reg, '0);
                end else begin
                  forkLock[req.pcx]        <= 1'b1;
                  forkEvt[req.pcx].frameArg <= req.frameArg;
                  reqBusy                  <= 1'b1;
                  state                    <= ST_POST_WRITE;
                end
              end
              OP_CLEAR: begin
                if (canReceive) begin
                  postedLock[req.pcx] <= 1'b0;
                  forkLock[req.pcx]   <= 1'b0;
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_DONE, 1'b1, req.thread_identifier_reg, '0);
                end else begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_DONE, 1'b0, req.thread_identifier_reg, '0);
                end
              end
              OP_FORBID: begin
                if (allocLock[req.pcx]) begin
                  threadMask[req.pcx] <= '0;
                  ans <= mkAns(RES_DONE, 1'b1, req.thread_identifier_reg, '0);
                end else begin
                  ans <= mkAns(RES_RESTART, 1'b0, req.thread_identifier_reg, '0);
                end
                ansValid <= 1'b1;
              end
              OP_TERMINATE: begin
                if (!allocLock[req.pcx]) begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_RESTART, 1'b0, req.thread_identifier_reg, '0);
                end else if (threadCount[req.pcx] > COUNT_WIDTH'(1)) begin
                  threadCount[req.pcx] <= countDown(threadCount[req.pcx]);
                  threadMask[req.pcx]  <= releaseSlot(threadMask[req.pcx], req.thread_identifier_reg);
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_IDLE, 1'b1, req.thread_identifier_reg, '0);
                end else if (!canReceive) begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_DEADLOCK_TRAP, 1'b0, req.thread_identifier_reg, '0);
                end else if (forkEvt[req.pcx].kind != KIND_SINGLE_POST) begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_DEADLOCK_EXC, 1'b0, req.thread_identifier_reg, '0);
                end else begin
                  // Last thread takes the single-post fork as itself
                  allocLock[req.pcx]  <= 1'b0;
                  postedLock[req.pcx] <= 1'b0;
                  heldCount    <= threadCount[req.pcx];
                  heldMask     <= threadMask[req.pcx];
                  acceptSingle <= 1'b1;
                  reqBusy      <= 1'b1;
                  state        <= ST_ACCEPT_READ;
                end
              end
              OP_JOIN: begin
                if (!allocLock[req.pcx]) begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_RESTART, 1'b0, req.thread_identifier_reg, '0);
                end else begin
                  allocLock[req.pcx] <= 1'b0;
                  heldCount <= threadCount[req.pcx];
                  heldMask  <= threadMask[req.pcx];
                  reqBusy   <= 1'b1;
                  state     <= ST_JOIN_DRAIN;
                end
              end
              OP_IDLE: begin
                // Search only the named context; caller allocation untouched
                if (acceptOk) begin
                  allocLock[req.pcx]  <= 1'b0;
                  postedLock[req.pcx] <= 1'b0;
                  heldCount    <= threadCount[req.pcx];
                  heldMask     <= threadMask[req.pcx] & ~bitOf(freeIndex);
                  cur.thread_identifier_reg      <= freeIndex;
                  acceptSingle <= 1'b0;
                  reqBusy      <= 1'b1;
                  state        <= ST_ACCEPT_READ;
                end else begin
                  ansValid <= 1'b1;
                  ans      <= mkAns(RES_IDLE, 1'b0, req.thread_identifier_reg, '0);
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_POST_WRITE: begin
          forkEvt[cur.pcx].targetPcStatus <= cur.targetPcStatus;
          forkEvt[cur.pcx].originPc       <= cur.originPc;
          state <= ST_POST_LOCK;
        end
        ST_POST_LOCK: begin
          forkEvt[cur.pcx].kind  <= postKind(cur.op);
          forkEvt[cur.pcx].stack <= cur.stack;
          postedLock[cur.pcx]    <= 1'b1;
          ansValid <= 1'b1;
          ans      <= mkAns(RES_DONE, 1'b1, cur.thread_identifier_reg, '0);
          reqBusy  <= 1'b0;
          state    <= ST_IDLE;
        end
        ST_JOIN_DRAIN: begin
          if (storesDrained) begin
            forkEvt[cur.pcx].kind <= KIND_HALTED;
            state <= ST_JOIN_FINISH;
          end
        end
        ST_JOIN_FINISH: begin
          allocLock[cur.pcx] <= 1'b1;
          ansValid <= 1'b1;
          if (heldCount > COUNT_WIDTH'(1)) begin
            threadCount[cur.pcx] <= countDown(heldCount);
            threadMask[cur.pcx]  <= releaseSlot(heldMask, cur.thread_identifier_reg);
            ans <= mkAns(RES_IDLE, 1'b1, cur.thread_identifier_reg, '0);
          end else begin
            ans <= mkAns(RES_CONTINUE, 1'b1, cur.thread_identifier_reg, '0);
          end
          reqBusy <= 1'b0;
          state   <= ST_IDLE;
        end
        ST_ACCEPT_READ: begin
          // Fields read while only the upper lock is held
          heldEvt <= forkEvt[cur.pcx];
          if (forkEvt[cur.pcx].kind == KIND_SINGLE_POST) begin
            forkLock[cur.pcx] <= 1'b0;
          end else begin
            postedLock[cur.pcx] <= 1'b1;
          end
          state <= ST_ACCEPT_DONE;
        end
        ST_ACCEPT_DONE: begin
          if (!acceptSingle && heldCount < COUNT_WIDTH'(THREAD_COUNT_MAX)) begin
            threadCount[cur.pcx] <= heldCount + COUNT_WIDTH'(1);
          end
          threadMask[cur.pcx] <= heldMask;
          allocLock[cur.pcx]  <= 1'b1;
          ansValid <= 1'b1;
          ans      <= mkAns(RES_ACCEPTED, 1'b1, cur.thread_identifier_reg, heldEvt);
          reqBusy  <= 1'b0;
          state    <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // Monitor view of a selected context
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      monPcx        <= '0;
      monForkLock   <= 1'b0;
      monPostedLock <= 1'b0;
      monAllocLock  <= 1'b0;
      monMask       <= '0;
      monCount      <= '0;
    end else begin
      monPcx        <= selPcx;
      monForkLock   <= forkLock[selPcx];
      monPostedLock <= postedLock[selPcx];
      monAllocLock  <= allocLock[selPcx];
      monMask       <= threadMask[selPcx];
      monCount      <= threadCount[selPcx];
    end
  end
endmodule

// file: test/fork_alloc_chk.sv
// Checker of request timing and answers of the fork allocator
`timescale 1ns/1ps
module fork_alloc_chk #(
  parameter int CONTEXTS = fork_pkg::PCX_COUNT
) (
  input wire logic                           ref_clk,
  input wire logic                           sys_rst,
  input wire logic                           reqValid,
  input wire fork_pkg::request_t             req,
  input wire logic                           storesDrained,
  input wire logic                           reqBusy,
  input wire logic                           ansValid,
  input wire fork_pkg::answer_t              ans,
  input wire logic [fork_pkg::PCX_WIDTH-1:0] monPcx,
  input wire logic                           monForkLock,
  input wire logic                           monPostedLock,
  input wire logic                           monAllocLock,
  input wire logic [fork_pkg::MASK_WIDTH-1:0]  monMask,
  input wire logic [fork_pkg::COUNT_WIDTH-1:0] monCount
);
  import fork_pkg::*;
  op_t  lastOp;
  logic take;
  assign take = reqValid && !reqBusy;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastOp <= OP_NONE;
    end else if (take) begin
      lastOp <= req.op;
    end
  end
  // ====
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence postFail;
    ansValid && !ans.carry;
  endsequence
  sequence postDone;
    reqBusy ##1 reqBusy ##1 (ansValid && ans.carry && !reqBusy);
  endsequence
  post_answer_a: assert property (take && (req.op == OP_POST_SINGLE || req.op == OP_POST_MULTI)
    |=> postFail or postDone) else $error("post answer wrong");
  clear_answer_a: assert property (take && req.op == OP_CLEAR |=> ansValid && !reqBusy)
    else $error("clear answer late");
  idle_answer_a: assert property (take && req.op == OP_IDLE |=> (ansValid && ans.result == RES_IDLE)
    or (reqBusy ##2 (ansValid && ans.result == RES_ACCEPTED))) else $error("idle answer wrong");
  count_range_a: assert property (monCount <= 6'h20) else $error("count above range");
  accept_kind_a: assert property (ansValid && ans.result == RES_ACCEPTED
    |-> ans.taken.kind inside {KIND_SINGLE_POST, KIND_MULTI_POST}) else $error("accepted bad kind");
  dead_source_a: assert property (ansValid && ans.result inside {RES_DEADLOCK_EXC, RES_DEADLOCK_TRAP}
    |-> lastOp == OP_TERMINATE) else $error("deadlock from wrong op");
  join_wait_a: assert property (reqBusy && lastOp == OP_JOIN && !storesDrained |=> !ansValid)
    else $error("join answered before drain");
  busy_end_a: assert property ($fell(reqBusy) |-> ansValid) else $error("busy fell without answer");
endmodule

bind fork_post_and_thread_allocator fork_alloc_chk #(.CONTEXTS(CONTEXTS)) chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
  .storesDrained(storesDrained), .reqBusy(reqBusy), .ansValid(ansValid), .ans(ans),
  .monPcx(monPcx), .monForkLock(monForkLock), .monPostedLock(monPostedLock),
  .monAllocLock(monAllocLock), .monMask(monMask), .monCount(monCount)
);

// file: test/fork_cpu_model.sv
// Model of a CPU issuing fork and thread operations
`timescale 1ns/1ps
module fork_cpu_model #(
  parameter int DRAIN_WAIT = 3
) (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               go,
  input  wire fork_pkg::request_t goReq,
  input  wire logic               reqBusy,
  input  wire logic               ansValid,
  output logic                    reqValid,
  output fork_pkg::request_t      req,
  output logic                    storesDrained
);
  import fork_pkg::*;
  int waitCnt;
  // Request held until taken, then frameArg and stack lines scrambled
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqValid <= 1'h0;
      req      <= '0;
    end else if (go) begin
      reqValid <= 1'h1;
      req      <= goReq;
    end else if (reqValid && !reqBusy) begin
      reqValid     <= 1'h0;
      req.frameArg <= ~req.frameArg;
      req.stack    <= ~req.stack;
    end
  end
  // Stores reach memory some cycles after a join is taken
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt       <= 0;
      storesDrained <= 1'h0;
    end else if (ansValid) begin
      waitCnt       <= 0;
      storesDrained <= 1'h0;
    end else if (reqBusy && req.op == OP_JOIN) begin
      if (waitCnt == DRAIN_WAIT) begin
        storesDrained <= 1'h1;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule

// file: test/fork_post_and_thread_allocator_bench.sv
// Testbench of the fork post and thread allocator
`timescale 1ns/1ps
module fork_post_and_thread_allocator_bench;
  import fork_pkg::*;
  logic                   ref_clk = 1'h0;
  logic                   sys_rst = 1'h1;
  logic                   go = 1'h0;
  request_t               goReq = '0;
  logic                   reqValid, storesDrained, reqBusy, ansValid;
  request_t               req;
  answer_t                ans;
  logic [PCX_WIDTH-1:0]   monPcx;
  logic                   monForkLock, monPostedLock, monAllocLock;
  logic [MASK_WIDTH-1:0]  monMask;
  logic [COUNT_WIDTH-1:0] monCount;
  int                     num_errors = 0;
  int                     checks_done = 0;

  always #5 ref_clk = ~ref_clk;

  fork_post_and_thread_allocator DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reqValid(reqValid),
    .req(req), .storesDrained(storesDrained), .reqBusy(reqBusy), .ansValid(ansValid), .ans(ans),
    .monPcx(monPcx), .monForkLock(monForkLock), .monPostedLock(monPostedLock),
    .monAllocLock(monAllocLock), .monMask(monMask), .monCount(monCount));
  fork_cpu_model cpu (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go), .goReq(goReq),
    .reqBusy(reqBusy), .ansValid(ansValid), .reqValid(reqValid), .req(req),
    .storesDrained(storesDrained));

  // ====
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic op(input op_t o, input logic [2:0] pcx, input logic [4:0] thread_identifier_reg);
    request_t r;
    int n;
    r = '0;
    r.op = o;
    r.pcx = pcx;
    r.thread_identifier_reg = thread_identifier_reg;
    r.frameArg = 32'h1111_2222;
    r.targetPcStatus = 32'h3333_4444;
    r.originPc = 32'h5555_6666;
    r.stack = 32'h7777_8888;
    @(posedge ref_clk);
    goReq <= r;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ansValid !== 1'h1 && n < 50);
    check(ansValid, 1'h1);
  endtask
  task automatic peek();
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ====
  // Scenarios
  task automatic t_reset();
    peek();
    check(monMask, MASK_RESET);
    check(monCount, COUNT_RESET);
    check(monAllocLock, 1'h1);
    check({monForkLock, monPostedLock}, 2'h0);
    $display("test reset done");
  endtask
  task automatic t_post();
    op(OP_POST_SINGLE, 3'h1, 5'h00);
    check(ans.carry, 1'h1);
    peek();
    check({monForkLock, monPostedLock}, 2'h3);
    check(monPcx, 3'h1);
    op(OP_POST_MULTI, 3'h1, 5'h00);
    check(ans.carry, 1'h0);
    op(OP_CLEAR, 3'h1, 5'h00);
    check(ans.carry, 1'h1);
    peek();
    check({monForkLock, monPostedLock}, 2'h0);
    op(OP_CLEAR, 3'h1, 5'h00);
    check(ans.carry, 1'h0);
    $display("test post clear done");
  endtask
  task automatic t_single();
    op(OP_POST_SINGLE, 3'h2, 5'h00);
    op(OP_IDLE, 3'h2, 5'h00);
    check(ans.result, RES_ACCEPTED);
    check(ans.thread_identifier_reg, 5'h01);
    check(ans.taken.kind, KIND_SINGLE_POST);
    check(ans.taken.originPc, 32'h5555_6666);
    check(ans.taken.frameArg, 32'h1111_2222);
    check(ans.taken.targetPcStatus, 32'h3333_4444);
    check(ans.taken.stack, 32'h7777_8888);
    peek();
    check(monMask, 32'hFFFF_FFFC);
    check(monCount, 6'h02);
    check(monForkLock, 1'h0);
    op(OP_TERMINATE, 3'h2, 5'h01);
    check(ans.result, RES_IDLE);
    peek();
    check(monMask, 32'hFFFF_FFFE);
    check(monCount, 6'h01);
    op(OP_TERMINATE, 3'h2, 5'h00);
    check(ans.result, RES_DEADLOCK_TRAP);
    op(OP_POST_SINGLE, 3'h2, 5'h00);
    check(ans.carry, 1'h1);
    op(OP_TERMINATE, 3'h2, 5'h00);
    check(ans.result, RES_ACCEPTED);
    check(ans.thread_identifier_reg, 5'h00);
    peek();
    check({monForkLock, monPostedLock}, 2'h0);
    check(monCount, 6'h01);
    $display("test single accept done");
  endtask
  task automatic t_multi();
    op(OP_POST_MULTI, 3'h3, 5'h00);
    op(OP_IDLE, 3'h3, 5'h00);
    check(ans.result, RES_ACCEPTED);
    check(ans.taken.kind, KIND_MULTI_POST);
    peek();
    check(monPostedLock, 1'h1);
    op(OP_JOIN, 3'h3, 5'h01);
    check(ans.result, RES_IDLE);
    peek();
    check(monCount, 6'h01);
    op(OP_IDLE, 3'h3, 5'h00);
    check({ans.result, ans.carry}, {RES_IDLE, 1'h0});
    op(OP_JOIN, 3'h3, 5'h00);
    check(ans.result, RES_CONTINUE);
    op(OP_TERMINATE, 3'h3, 5'h00);
    check(ans.result, RES_DEADLOCK_EXC);
    $display("test multi join done");
  endtask
  task automatic t_forbid();
    op(OP_FORBID, 3'h4, 5'h00);
    check(ans.carry, 1'h1);
    op(OP_POST_SINGLE, 3'h4, 5'h00);
    op(OP_IDLE, 3'h4, 5'h00);
    check(ans.result, RES_IDLE);
    peek();
    check(monMask, 32'h0000_0000);
    check(monCount, 6'h01);
    $display("test forbid done");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_reset();
    t_post();
    t_single();
    t_multi();
    t_forbid();
    results();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    results();
  end
endmodule
